// [async_serial_cfg.svh]
`ifndef ASYNC_SERIAL_CFG_SVH
`define ASYNC_SERIAL_CFG_SVH

// Oversample ticks per bit minus one
`define OS_MAX_DIV16 4'hF
`define OS_MAX_DIV8 4'h7
// Infrared pulse width in oversample ticks (3/16 of a bit, or 2/8 in high-speed mode)
`define IR_NORM_TICKS_DIV16 4'h3
`define IR_NORM_TICKS_DIV8 4'h2
// Low-power infrared pulse width in divided reference ticks
`define IR_LP_TICKS 2'h3
// FIFO trigger levels in eighths of depth
`define LVL_EIGHTHS_1_8 1
`define LVL_EIGHTHS_1_4 2
`define LVL_EIGHTHS_1_2 4
`define LVL_EIGHTHS_3_4 6
`define LVL_EIGHTHS_7_8 7
// Idle level of the serial line
`define LINE_IDLE 1'b1
// Fixed character length in 9-bit and smart-card modes, and base of the 5 to 8 bit range
`define NB_NINE 4'h9
`define NB_CARD 4'h8
`define NB_BASE 4'h5

`endif

// [async_serial_pkg.sv]
`default_nettype none
package async_serial_pkg;

  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic high_speed;
    logic [1:0] wlen;
    logic par_en;
    logic par_even;
    logic par_stick;
    logic two_stop;
    logic send_break;
    logic fifo_en;
    logic [2:0] rx_lvl;
    logic [2:0] tx_lvl;
    logic ir_en;
    logic ir_low_power;
    logic nine_bit;
    logic card_en;
    logic clk_sel_alt;
    logic cts_en;
    logic rts_en;
  } cfg_t;

  typedef struct packed {
    logic rx;
    logic tx;
    logic flow;
    logic modem;
    logic err;
    logic eot;
  } int_t;

  typedef struct packed {
    logic frame;
    logic parity;
    logic brk;
    logic overrun;
  } err_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_START = 3'h1,
    TX_DATA = 3'h3,
    TX_PAR = 3'h2,
    TX_STOP = 3'h6
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_PAR = 3'h2,
    RX_STOP = 3'h6,
    RX_NACK = 3'h7
  } rx_state_t;

endpackage
`default_nettype wire

// [async_serial_transceiver.sv]
// Functional notes
// - One interrupt output, high when any unmasked source is active.
// - Receive, transmit, flow, modem status and error sources each maskable.
// - Oversampling by 16 normally, by 8 in high-speed mode.
// - Separate transmit and receive FIFOs, sixteen entries each.
// - FIFO disable gives one-entry double-buffered holding registers.
// - Trigger level of 1/8, 1/4, 1/2, 3/4 or 7/8 depth.
// - Five to eight data bits, both directions.
// - Even, odd, stick or no parity; receiver flags mismatch.
// - One or two stop bits sent.
// - Break sent on command in plain serial mode only; received break detected and reported.
// - Infrared codec or plain serial selected by configuration.
// - Infrared mode is half-duplex.
// - Infrared pulses of 3/16 bit (2/8 bit in high-speed mode), or fixed low-power width.
// - Divider of 1 to 256 times the low-power pulse.
// - Modem status inputs are an instance option; flow lines always present.
// - Nine-bit mode, ninth bit marks an address character.
// - FIFO-level and end-of-transmission interrupts.
// - Receive DMA single when data present, burst at trigger level.
// - Transmit DMA single when space free, burst at trigger level.
// - Baud generator clocked from core or alternate clock source.
// - Smart-card mode: 8 bits, even parity, guard time, error NACK.
// - Transmitter and receiver keep independent bit timing.
`timescale 1ns/1ps
`default_nettype none
`include "async_serial_cfg.svh"
module async_serial_transceiver #(
  parameter int DEPTH = 16,
  parameter bit MODEM_STATUS = 1'b1
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire async_serial_pkg::cfg_t cfg,
  input wire logic [15:0] baud_div,
  input wire logic [7:0] ir_lp_div,
  input wire logic alternate_clock_source,
  input wire logic [8:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [8:0] rx_data,
  output logic rx_valid,
  input wire logic rx_pop,
  input wire logic rxd,
  output logic txd,
  input wire logic ir_rx,
  output logic ir_tx,
  input wire logic cts_n,
  output logic rts_n,
  input wire logic dsr_n,
  input wire logic dcd_n,
  input wire logic ri_n,
  input wire async_serial_pkg::int_t int_mask,
  input wire async_serial_pkg::int_t int_clear,
  output async_serial_pkg::int_t int_status,
  output logic irq,
  input wire async_serial_pkg::err_t err_clear,
  output async_serial_pkg::err_t err_status,
  output logic tx_busy,
  output logic rx_dma_single,
  output logic rx_dma_burst,
  output logic tx_dma_single,
  output logic tx_dma_burst
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][8:0] tmem;
    logic [AW-1:0] twp;
    logic [AW-1:0] trp;
    logic [CW-1:0] tcnt;
    logic [DEPTH-1:0][8:0] rmem;
    logic [AW-1:0] rwp;
    logic [AW-1:0] rrp;
    logic [CW-1:0] rcnt;
    async_serial_pkg::tx_state_t ts;
    logic [3:0] tos;
    logic [3:0] tbits;
    logic [8:0] tsh;
    logic tpar;
    logic tstop2;
    logic tline;
    async_serial_pkg::rx_state_t rs;
    logic [3:0] ros;
    logic [3:0] rbits;
    logic [8:0] rsh;
    logic rperr;
    logic rnack;
    logic [15:0] bcnt;
    logic [7:0] lpcnt;
    logic [1:0] lpw;
    logic [3:0] irh;
    logic cts_q;
    logic dsr_q;
    logic dcd_q;
    logic ri_q;
    async_serial_pkg::int_t sticky;
    async_serial_pkg::err_t err;
    logic txo;
    logic irtxo;
  } st_t;

  st_t st_reg;
  st_t st_next;

  function automatic logic [CW-1:0] thr(input logic fifo_en, input logic [2:0] lvl);
    int e;
    case (lvl)
      3'h0: e = `LVL_EIGHTHS_1_8;
      3'h1: e = `LVL_EIGHTHS_1_4;
      3'h2: e = `LVL_EIGHTHS_1_2;
      3'h3: e = `LVL_EIGHTHS_3_4;
      default: e = `LVL_EIGHTHS_7_8;
    endcase
    thr = fifo_en ? CW'((DEPTH * e) / 8) : CW'(1);
  endfunction

  logic [CW-1:0] deff, rthr, tthr;
  logic [3:0] osm, nb;
  logic [8:0] nmask, rdat;
  logic usep, even, stick, two, src, tick, lptick, rline, tpush, tpop, rpush, rpop;
  logic tend, rsamp, bitstart, par_rx;
  async_serial_pkg::int_t raw, iset;
  async_serial_pkg::err_t eset;

  always_comb begin
    st_next = st_reg;
    tpop = 1'b0;
    rpush = 1'b0;
    bitstart = 1'b0;
    iset = '0;
    eset = '0;
    deff = cfg.fifo_en ? CW'(DEPTH) : CW'(1);
    rthr = thr(cfg.fifo_en, cfg.rx_lvl);
    tthr = thr(cfg.fifo_en, cfg.tx_lvl);
    osm = cfg.high_speed ? `OS_MAX_DIV8 : `OS_MAX_DIV16;
    nb = cfg.card_en ? `NB_CARD : cfg.nine_bit ? `NB_NINE : `NB_BASE + {2'h0, cfg.wlen};
    nmask = 9'h1FF >> (4'h9 - nb);
    usep = cfg.card_en | (cfg.par_en & ~cfg.nine_bit);
    even = cfg.card_en | cfg.par_even;
    stick = ~cfg.card_en & cfg.par_stick;
    two = cfg.card_en | cfg.two_stop;
    // Baud tick from the selected clock source
    src = cfg.clk_sel_alt ? alternate_clock_source : 1'b1;
    tick = src && (st_reg.bcnt == 16'h0000);
    if (src) begin
      st_next.bcnt = (st_reg.bcnt == 16'h0000) ?
        ((baud_div == 16'h0000) ? 16'h0000 : baud_div - 16'h0001) : st_reg.bcnt - 16'h0001;
    end
    lptick = (st_reg.lpcnt == 8'h00);
    st_next.lpcnt = lptick ? ir_lp_div : st_reg.lpcnt - 8'h01;
    // Transmit FIFO write side
    tpush = tx_valid && (st_reg.tcnt < deff);
    if (tpush) begin
      st_next.tmem[st_reg.twp] = tx_data & nmask;
      st_next.twp = st_reg.twp + AW'(1);
    end
    // Transmitter, own oversample counter
    tend = tick && (st_reg.tos == osm);
    case (st_reg.ts)
      async_serial_pkg::TX_IDLE: begin
        if (cfg.tx_en && st_reg.tcnt != '0 && !(cfg.cts_en && cts_n) && tick) begin
          tpop = 1'b1;
          st_next.tsh = st_reg.tmem[st_reg.trp];
          st_next.tpar = stick ? ~even : (^st_reg.tmem[st_reg.trp]) ^ ~even;
          st_next.ts = async_serial_pkg::TX_START;
          st_next.tos = 4'h0;
          st_next.tline = 1'b0;
          bitstart = 1'b1;
        end
      end
      async_serial_pkg::TX_START: begin
        if (tend) begin
          st_next.ts = async_serial_pkg::TX_DATA;
          st_next.tbits = 4'h0;
          st_next.tline = st_reg.tsh[0];
          bitstart = 1'b1;
        end
      end
      async_serial_pkg::TX_DATA: begin
        if (tend) begin
          st_next.tsh = st_reg.tsh >> 1;
          st_next.tbits = st_reg.tbits + 4'h1;
          bitstart = 1'b1;
          if (st_reg.tbits == nb - 4'h1) begin
            st_next.ts = usep ? async_serial_pkg::TX_PAR : async_serial_pkg::TX_STOP;
            st_next.tline = usep ? st_reg.tpar : `LINE_IDLE;
            st_next.tstop2 = two;
          end else begin
            st_next.tline = st_reg.tsh[1];
          end
        end
      end
      async_serial_pkg::TX_PAR: begin
        if (tend) begin
          st_next.ts = async_serial_pkg::TX_STOP;
          st_next.tline = `LINE_IDLE;
          st_next.tstop2 = two;
        end
      end
      async_serial_pkg::TX_STOP: begin
        if (tend) begin
          st_next.tstop2 = 1'b0;
          if (!st_reg.tstop2) begin
            st_next.ts = async_serial_pkg::TX_IDLE;
            iset.eot = (st_reg.tcnt == '0) && !tpush;
          end
        end
      end
      default: begin
        st_next.ts = async_serial_pkg::TX_IDLE;
        st_next.tline = `LINE_IDLE;
      end
    endcase
    if (tick) begin
      st_next.tos = (st_reg.ts == async_serial_pkg::TX_IDLE || tend) ? 4'h0 : st_reg.tos + 4'h1;
    end
    if (tpop) begin
      st_next.trp = st_reg.trp + AW'(1);
    end
    st_next.tcnt = st_reg.tcnt + CW'(tpush) - CW'(tpop);
    // Infrared decoder stretches a pulse over one bit
    if (ir_rx) begin
      st_next.irh = osm;
    end else if (tick && st_reg.irh != 4'h0) begin
      st_next.irh = st_reg.irh - 4'h1;
    end
    rline = cfg.ir_en ? ((~ir_rx && st_reg.irh == 4'h0) || st_reg.ts != async_serial_pkg::TX_IDLE) : rxd;
    // Receiver, own oversample counter
    rsamp = tick && (st_reg.ros == osm);
    rdat = (st_reg.rsh >> (4'h9 - nb)) & nmask;
    par_rx = stick ? ~even : (^rdat) ^ ~even;
    if (tick) begin
      st_next.ros = rsamp ? 4'h0 : st_reg.ros + 4'h1;
    end
    case (st_reg.rs)
      async_serial_pkg::RX_IDLE: begin
        st_next.ros = 4'h0;
        if (tick && cfg.rx_en && !rline) begin
          st_next.rs = async_serial_pkg::RX_START;
          st_next.rperr = 1'b0;
        end
      end
      async_serial_pkg::RX_START: begin
        if (tick && st_reg.ros == (osm >> 1)) begin
          st_next.ros = 4'h0;
          st_next.rbits = 4'h0;
          st_next.rs = rline ? async_serial_pkg::RX_IDLE : async_serial_pkg::RX_DATA;
        end
      end
      async_serial_pkg::RX_DATA: begin
        if (rsamp) begin
          st_next.rsh = {rline, st_reg.rsh[8:1]};
          st_next.rbits = st_reg.rbits + 4'h1;
          if (st_reg.rbits == nb - 4'h1) begin
            st_next.rs = usep ? async_serial_pkg::RX_PAR : async_serial_pkg::RX_STOP;
          end
        end
      end
      async_serial_pkg::RX_PAR: begin
        if (rsamp) begin
          st_next.rperr = (rline != par_rx);
          st_next.rs = async_serial_pkg::RX_STOP;
        end
      end
      async_serial_pkg::RX_STOP: begin
        if (rsamp) begin
          rpush = 1'b1;
          eset.frame = !rline;
          eset.parity = st_reg.rperr;
          eset.brk = !rline && rdat == 9'h000;
          st_next.rs = (cfg.card_en && st_reg.rperr) ? async_serial_pkg::RX_NACK : async_serial_pkg::RX_IDLE;
          st_next.rnack = cfg.card_en && st_reg.rperr;
        end
      end
      async_serial_pkg::RX_NACK: begin
        if (rsamp) begin
          st_next.rnack = 1'b0;
          st_next.rs = async_serial_pkg::RX_IDLE;
        end
      end
      default: begin
        st_next.rs = async_serial_pkg::RX_IDLE;
      end
    endcase
    // Receive FIFO
    rpop = rx_pop && (st_reg.rcnt != '0);
    if (rpush && (st_reg.rcnt >= deff) && !rpop) begin
      eset.overrun = 1'b1;
      rpush = 1'b0;
    end
    if (rpush) begin
      st_next.rmem[st_reg.rwp] = rdat;
      st_next.rwp = st_reg.rwp + AW'(1);
    end
    if (rpop) begin
      st_next.rrp = st_reg.rrp + AW'(1);
    end
    st_next.rcnt = st_reg.rcnt + CW'(rpush) - CW'(rpop);
    // Modem lines
    st_next.cts_q = cts_n;
    st_next.dsr_q = dsr_n;
    st_next.dcd_q = dcd_n;
    st_next.ri_q = ri_n;
    iset.flow = (st_reg.cts_q != cts_n);
    iset.modem = MODEM_STATUS && ((st_reg.dsr_q != dsr_n) || (st_reg.dcd_q != dcd_n) || (st_reg.ri_q != ri_n));
    // Sticky flags, a new event wins over a clear
    st_next.sticky = (st_reg.sticky & ~int_clear) | iset;
    st_next.err = (st_reg.err & ~err_clear) | eset;
    // Infrared encoder
    if (bitstart && !st_next.tline) begin
      st_next.lpw = `IR_LP_TICKS;
    end else if (lptick && st_reg.lpw != 2'h0) begin
      st_next.lpw = st_reg.lpw - 2'h1;
    end
    if (cfg.ir_low_power) begin
      st_next.irtxo = cfg.ir_en && st_next.lpw != 2'h0;
    end else begin
      st_next.irtxo = cfg.ir_en && st_next.ts != async_serial_pkg::TX_IDLE && !st_next.tline &&
        st_next.tos < (cfg.high_speed ? `IR_NORM_TICKS_DIV8 : `IR_NORM_TICKS_DIV16);
    end
    st_next.txo = cfg.ir_en ? `LINE_IDLE : (st_next.tline && !cfg.send_break && !st_next.rnack);
    raw.rx = st_reg.rcnt >= rthr;
    raw.tx = cfg.tx_en && (st_reg.tcnt < tthr);
    raw.flow = st_reg.sticky.flow;
    raw.modem = st_reg.sticky.modem;
    raw.err = |st_reg.err;
    raw.eot = st_reg.sticky.eot;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.tline <= `LINE_IDLE;
      st_reg.txo <= `LINE_IDLE;
      st_reg.cts_q <= 1'b1;
      st_reg.dsr_q <= 1'b1;
      st_reg.dcd_q <= 1'b1;
      st_reg.ri_q <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign txd = st_reg.txo;
  assign ir_tx = st_reg.irtxo;
  assign tx_ready = st_reg.tcnt < deff;
  assign rx_valid = st_reg.rcnt != '0;
  assign rx_data = st_reg.rmem[st_reg.rrp];
  assign rts_n = cfg.rts_en && (st_reg.rcnt >= rthr);
  assign int_status = raw;
  assign irq = |(raw & int_mask);
  assign err_status = st_reg.err;
  assign tx_busy = st_reg.ts != async_serial_pkg::TX_IDLE;
  assign rx_dma_single = st_reg.rcnt != '0;
  assign rx_dma_burst = st_reg.rcnt >= rthr;
  assign tx_dma_single = st_reg.tcnt < deff;
  assign tx_dma_burst = st_reg.tcnt < tthr;
endmodule
`default_nettype wire

// [async_serial_transceiver_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module async_serial_transceiver_properties (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire async_serial_pkg::cfg_t cfg,
  input wire logic [15:0] baud_div,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic txd,
  input wire async_serial_pkg::int_t int_mask,
  input wire async_serial_pkg::int_t int_status,
  input wire logic irq,
  input wire async_serial_pkg::err_t err_status,
  input wire logic tx_busy,
  input wire logic rx_dma_single,
  input wire logic tx_dma_single
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  property p_irq;
    irq == |(int_status & int_mask);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq differs from masked sources");
  property p_err;
    int_status.err == |err_status;
  endproperty
  a_err: assert property (p_err)
    else $error("error source differs from error flags");
  property p_rx_single;
    rx_dma_single == rx_valid;
  endproperty
  a_rx_single: assert property (p_rx_single)
    else $error("receive single request differs from data present");
  property p_tx_single;
    cfg.fifo_en |-> tx_dma_single == tx_ready;
  endproperty
  a_tx_single: assert property (p_tx_single)
    else $error("transmit single request differs from free space");
  property p_one_entry;
    !cfg.fifo_en && !cfg.tx_en && tx_valid && tx_ready |=> !tx_ready;
  endproperty
  a_one_entry: assert property (p_one_entry)
    else $error("one-entry mode took a second word");
  property p_brk;
    cfg.send_break && $past(cfg.send_break) |-> !txd;
  endproperty
  a_brk: assert property (p_brk)
    else $error("line not low during break");
  property p_ir_quiet;
    cfg.ir_en && $past(cfg.ir_en) && !cfg.send_break |-> txd;
  endproperty
  a_ir_quiet: assert property (p_ir_quiet)
    else $error("plain output active in infrared mode");
  property p_idle;
    !tx_busy && !cfg.send_break && !$past(cfg.send_break) && !cfg.card_en |-> txd;
  endproperty
  a_idle: assert property (p_idle)
    else $error("line not high while idle");
  property p_start;
    $fell(txd) && !cfg.send_break && !$past(cfg.send_break) && baud_div == 16'h0001 |-> !txd [*8];
  endproperty
  a_start: assert property (p_start)
    else $error("start bit shorter than eight ticks");
  c_tx_done: cover property ($fell(tx_busy));
  c_rx_data: cover property ($rose(rx_valid));
  c_irq: cover property ($rose(irq));
endmodule
bind async_serial_transceiver async_serial_transceiver_properties u_async_serial_transceiver_properties (
  .ref_clk(ref_clk), .nrst(nrst), .cfg(cfg), .baud_div(baud_div), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .rx_valid(rx_valid), .txd(txd), .int_mask(int_mask), .int_status(int_status),
  .irq(irq), .err_status(err_status), .tx_busy(tx_busy), .rx_dma_single(rx_dma_single),
  .tx_dma_single(tx_dma_single)
);
`default_nettype wire

// [async_serial_transceiver_test.sv]
`timescale 1ns/1ps
`default_nettype none
module async_serial_transceiver_test;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  async_serial_pkg::cfg_t cfg = '0;
  async_serial_pkg::int_t int_mask = '0;
  async_serial_pkg::int_t int_clear = '0;
  async_serial_pkg::int_t int_status;
  async_serial_pkg::err_t err_clear = '0;
  async_serial_pkg::err_t err_status;
  logic [7:0] ir_lp_div = 8'h00;
  logic [8:0] tx_data = 9'h000;
  logic [8:0] rx_data;
  logic tx_valid = 1'b0;
  logic rx_pop = 1'b0;
  logic [3:0] mdm = 4'hF;
  logic [4:0] bit_len = 5'h10;
  logic tx_ready, rx_valid, rxd, txd, ir_tx, irq, tx_busy, rx_ds, rx_db, tx_ds, tx_db;
  logic [7:0] d, m;
  logic [11:0] f;
  int seed = 52748;
  int mismatches = 0;
  int checks_done = 0;
  int n, thr, busy, hi, n0;
  logic [15:0] thr_exp [6] = '{16'h0002, 16'h0004, 16'h0008, 16'h000C, 16'h000E, 16'h0001};
  always #5 ref_clk = ~ref_clk;
  async_serial_transceiver u_async_serial_transceiver (
    .ref_clk(ref_clk), .nrst(nrst), .cfg(cfg), .baud_div(16'h0001), .ir_lp_div(ir_lp_div),
    .alternate_clock_source(1'b0), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_pop(rx_pop), .rxd(rxd), .txd(txd), .ir_rx(1'b0),
    .ir_tx(ir_tx), .cts_n(mdm[3]), .rts_n(), .dsr_n(mdm[2]), .dcd_n(mdm[1]), .ri_n(mdm[0]),
    .int_mask(int_mask), .int_clear(int_clear), .int_status(int_status), .irq(irq),
    .err_clear(err_clear), .err_status(err_status), .tx_busy(tx_busy), .rx_dma_single(rx_ds),
    .rx_dma_burst(rx_db), .tx_dma_single(tx_ds), .tx_dma_burst(tx_db)
  );
  serial_peer u_serial_peer (.ref_clk(ref_clk), .bit_len(bit_len), .line_in(txd), .line_out(rxd));
  function automatic int nb(input async_serial_pkg::cfg_t c);
    return 5 + c.wlen;
  endfunction
  function automatic logic [7:0] mask(input async_serial_pkg::cfg_t c, input logic [7:0] v);
    return v & ~(8'hFF << nb(c));
  endfunction
  function automatic logic [11:0] cells(input async_serial_pkg::cfg_t c, input logic [7:0] v);
    logic [11:0] r;
    logic [7:0] w;
    r = 12'hFFE;
    w = mask(c, v);
    for (int i = 0; i < nb(c); i++) r[i + 1] = w[i];
    if (c.par_en) r[nb(c) + 1] = c.par_stick ? ~c.par_even : (c.par_even ? ^w : ~^w);
    return r;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    checks_done++;
    if (seen !== expected) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask
  task automatic complete_run;
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic push(input logic [8:0] v);
    tx_data = v;
    tx_valid = 1'b1;
    @(negedge ref_clk);
    tx_valid = 1'b0;
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    check({12'h000, txd, tx_ready, rx_valid, irq}, 16'h000C);
    for (int it = 0; it < 8; it++) begin
      cfg = '0;
      {cfg.wlen, cfg.par_en, cfg.par_even, cfg.par_stick, cfg.two_stop, cfg.high_speed} = 7'($random(seed));
      {cfg.tx_en, cfg.rx_en, cfg.fifo_en} = 3'h7;
      cfg.rts_en = it[0];
      if (it == 3) cfg.par_en = 1'b1;
      if (it == 5) cfg.par_en = 1'b0;
      bit_len = cfg.high_speed ? 5'h08 : 5'h10;
      {mdm, int_mask, int_clear} = 16'($random(seed));
      ir_lp_div = 8'($random(seed));
      d = 8'($random(seed));
      m = 8'($random(seed));
      n0 = u_serial_peer.cap_count;
      fork
        begin
          push({1'b0, d});
          busy = 0;
          for (int k = 0; k < 400 && (busy == 0 || tx_busy); k++) begin
            if (tx_busy === 1'b1) busy++;
            @(negedge ref_clk);
          end
          check(16'((busy + 2) / bit_len), 16'(2 + nb(cfg) + cfg.par_en + cfg.two_stop));
        end
        begin
          f = cells(cfg, m);
          if (it == 3) f[nb(cfg) + 1] = ~f[nb(cfg) + 1];
          if (it == 5) f = 12'hFFF << (nb(cfg) + 2);
          u_serial_peer.send_cells(f);
          check({6'h00, rx_ds, rx_data}, 16'h0200 | (it == 5 ? 8'h00 : mask(cfg, m)));
          check({15'h0000, rx_db}, 16'h0000);
          check({12'h000, err_status}, it == 3 ? 16'h0004 : it == 5 ? 16'h000A : 16'h0000);
        end
      join
      for (int k = 0; k < 300 && u_serial_peer.cap_count == n0; k++) @(negedge ref_clk);
      check({4'h0, u_serial_peer.cap}, {4'h0, cells(cfg, d)});
      rx_pop = 1'b1;
      err_clear = 4'hF;
      @(negedge ref_clk);
      rx_pop = 1'b0;
      err_clear = 4'h0;
      check({12'h000, rx_valid, err_status[3:1]}, 16'h0000);
    end
    cfg = '0;
    {cfg.tx_en, cfg.fifo_en, cfg.ir_en} = 3'h7;
    bit_len = 5'h10;
    push(9'h000);
    hi = 0;
    repeat (220) begin
      if (ir_tx === 1'b1) hi++;
      @(negedge ref_clk);
    end
    check(16'(hi), 16'h0012);
    cfg.ir_en = 1'b0;
    cfg.send_break = 1'b1;
    repeat (20) @(negedge ref_clk);
    check({15'h0000, txd}, 16'h0000);
    cfg.send_break = 1'b0;
    for (int lv = 0; lv < 6; lv++) begin
      nrst = 1'b0;
      repeat (2) @(negedge ref_clk);
      nrst = 1'b1;
      cfg = '0;
      cfg.fifo_en = (lv < 5);
      cfg.tx_lvl = 3'(lv);
      n = 0;
      thr = 0;
      tx_valid = 1'b1;
      while (tx_ready === 1'b1 && n < 20) begin
        tx_data = 9'($random(seed));
        @(negedge ref_clk);
        n++;
        if (thr == 0 && tx_db !== 1'b1) thr = n;
      end
      tx_valid = 1'b0;
      check(16'(n), lv < 5 ? 16'h0010 : 16'h0001);
      check(16'(thr), thr_exp[lv]);
      check({15'h0000, tx_ds}, 16'h0000);
    end
    complete_run();
  end
  initial begin
    #300000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire

// [serial_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic ref_clk,
  input wire logic [4:0] bit_len,
  input wire logic line_in,
  output logic line_out
);
  logic [11:0] cap;
  int cap_count;
  initial begin
    line_out = 1'b1;
    cap = 12'hFFF;
    cap_count = 0;
  end
  // Cells go out first to last, line back to idle high
  task automatic send_cells(input logic [11:0] cells);
    for (int i = 0; i < 12; i++) begin
      line_out <= cells[i];
      repeat (bit_len) @(negedge ref_clk);
    end
    line_out <= 1'b1;
  endtask
  // Twelve cells sampled at bit centres after a falling edge
  always begin
    @(negedge line_in);
    repeat (bit_len / 2) @(negedge ref_clk);
    for (int i = 0; i < 12; i++) begin
      cap[i] = line_in;
      if (i < 11) repeat (bit_len) @(negedge ref_clk);
    end
    cap_count++;
    wait (line_in);
  end
endmodule
`default_nettype wire
